// ===== dv/fpu_cp_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module fpu_cp_asserts #(
   parameter int         PORT_W = 32,
   parameter logic [2:0] CP_ID  = 3'h1
) (
   // Interface signals
   input  wire logic        clk_sys,
   input  wire logic        reset,
   input  wire logic        cyc,
   input  wire logic        wr,
   input  wire logic [2:0]  fc,
   input  wire logic [2:0]  cp_id,
   input  wire logic [4:0]  cir_sel,
   input  wire logic [31:0] wdata,
   input  wire logic [31:0] rdata,
   input  wire logic [1:0]  size_acknowledge
);
   import fpu_cp_pkg::*;
   wire logic [1:0] ack_w = (PORT_W == 8) ? ACK_BYTE :
                            (PORT_W == 16) ? ACK_WORD : ACK_LONG;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   ////////////////////////////////////////////////////////////////////////
   sequence s_take;
      $rose(cyc) && size_acknowledge == ACK_NONE && fc == FC_CPU_SPACE;
   endsequence
   sequence s_read(logic [4:0] sel);
      s_take ##0 (!wr && cir_sel == sel);
   endsequence
   chk_ack_after_take: assert property (s_take ##0 cp_id == CP_ID
      |=> size_acknowledge == ack_w) else $error("ack missing");
   chk_foreign_id: assert property (cyc && cp_id != CP_ID
      |=> size_acknowledge == ACK_NONE) else $error("foreign id acked");
   chk_cpu_space: assert property (cyc |-> fc == FC_CPU_SPACE)
      else $error("bad function code");
   chk_ack_stands: assert property (
      size_acknowledge != ACK_NONE && cyc
      |=> size_acknowledge == $past(size_acknowledge) && $stable(rdata))
      else $error("ack dropped early");
   chk_ack_release: assert property (
      size_acknowledge != ACK_NONE && !cyc
      |=> size_acknowledge == ACK_NONE) else $error("ack held");
   chk_host_waits: assert property ($rose(cyc)
      |-> size_acknowledge == ACK_NONE) else $error("early strobe");
   chk_resp_code: assert property (s_read(CIR_RESPONSE) |=>
      rdata[15:0] inside {RESP_RELEASE, RESP_FETCH, RESP_BUSY})
      else $error("bad response");
   chk_save_format: assert property (s_read(CIR_SAVE) |=>
      rdata[15:0] inside {FMT_NULL, FMT_AGAIN, FMT_IDLE, FMT_BUSY})
      else $error("bad save format");
endmodule : fpu_cp_asserts
`default_nettype wire

// ===== dv/test_fpu_coprocessor_interface.sv
`timescale 1ns/1ns
`default_nettype none
module test_fpu_coprocessor_interface;
   import fpu_cp_pkg::*;
   logic        clk_sys    = 1'b0;
   logic        reset      = 1'b1;
   logic        op_valid   = 1'b0;
   host_op_e    op_kind    = OP_EXEC;
   logic [15:0] op_cmd     = 16'h0000;
   logic [31:0] op_operand = 32'h0000_0000;
   logic        op_ready;
   logic        op_done;
   logic        cp_busy;
   logic [15:0] op_resp;
   logic [15:0] resp;
   logic [31:0] rnd;
   cp_state_e   cp_state;
   int          num_errors = 0;
   int          n_tests    = 0;
   cp_bus_if bus ();
   fpu_cp_device #(.PORT_W(32), .CP_ID(3'h1)) fpu_cp_device_i (
      .clk_sys(clk_sys), .reset(reset), .bus(bus),
      .cp_state(cp_state), .cp_busy(cp_busy));
   fpu_cp_host #(.PORT_W(32), .CP_ID(3'h1)) fpu_cp_host_i (
      .clk_sys(clk_sys), .reset(reset), .bus(bus),
      .op_valid(op_valid), .op_kind(op_kind), .op_cmd(op_cmd),
      .op_operand(op_operand), .op_ready(op_ready),
      .op_done(op_done), .op_resp(op_resp));
   // Checker keeps its defaults, which match the two ends above
   fpu_cp_asserts fpu_cp_asserts_i (
      .clk_sys(clk_sys), .reset(reset), .cyc(bus.cyc), .wr(bus.wr),
      .fc(bus.fc), .cp_id(bus.cp_id), .cir_sel(bus.cir_sel),
      .wdata(bus.wdata), .rdata(bus.rdata),
      .size_acknowledge(bus.size_acknowledge));
   ////////////////////////////////////////////////////////////////////////
   task automatic complete_run;
      $display("Checks %0d errors %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : complete_run
   task automatic check(input string name, input logic [31:0] seen, exp);
      n_tests++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   function automatic logic [15:0] save_fmt(input cp_state_e st);
      return (st == ST_NULL) ? FMT_NULL : (st == ST_IDLE) ? FMT_IDLE
                                                          : FMT_BUSY;
   endfunction : save_fmt
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : tick
   task automatic wait_busy(input logic v);
      for (int n = 0; n < 999 && cp_busy !== v; n++)
         tick(1);
      if (cp_busy !== v)
         num_errors++;
   endtask : wait_busy
   task automatic run_op(input host_op_e k, input logic [15:0] c,
                         input logic [31:0] d);
      for (int n = 0; n < 99 && op_ready !== 1'b1; n++)
         tick(1);
      if (op_ready !== 1'b1)
         num_errors++;
      op_valid = 1'b1;
      op_kind = k;
      op_cmd = c;
      op_operand = d;
      tick(1);
      op_valid = 1'b0;
      for (int n = 0; n < 3000 && op_done !== 1'b1; n++)
         tick(1);
      if (op_done !== 1'b1)
         num_errors++;
      resp = op_resp;
   endtask : run_op
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      forever #5 clk_sys = ~clk_sys;
   end
   initial
   begin
      #200000;
      num_errors++;
      complete_run();
   end
   initial
   begin
      void'($urandom(72779));
      tick(8);
      reset = 1'b0;
      check("state", cp_state, ST_NULL);
      run_op(OP_SAVE, 16'h0000, 32'h0000_0000);
      check("null save", resp, save_fmt(ST_NULL));
      repeat (3)
      begin
         rnd = $urandom;
         run_op(OP_EXEC, {1'b1, rnd[14:0]}, $urandom);
         check("exec", resp, RESP_RELEASE);
         run_op(OP_SAVE, 16'h0000, 32'h0000_0000);
         check("busy save", resp, save_fmt(ST_BUSY));
         tick(2);
         check("halted", cp_busy, 1'b0);
         run_op(OP_RESTORE, 16'h0000, 32'h0000_0000);
         tick(2);
         check("resumed", cp_busy, 1'b1);
         wait_busy(1'b0);
         run_op(OP_EXEC, {1'b0, rnd[30:16]}, 32'h0000_0000);
         check("no fetch", resp, RESP_RELEASE);
         wait_busy(1'b1);
         // Save lands with under SAVE_COST cycles left: retry, then idle
         tick(20);
         run_op(OP_SAVE, 16'h0000, 32'h0000_0000);
         check("late save", resp, save_fmt(ST_IDLE));
         run_op(OP_RESET, 16'h0000, 32'h0000_0000);
         tick(2);
         check("null restore", cp_state, ST_NULL);
      end
      complete_run();
   end
endmodule : test_fpu_coprocessor_interface
`default_nettype wire

// ===== hw/cp_chunk_packer.sv
`timescale 1ns/1ns
`default_nettype none
module cp_chunk_packer #(
   parameter int PORT_W = 32
) (
   // Clock and reset
   input  wire logic              clk_sys,
   input  wire logic              reset,
   // Access stream
   input  wire logic              step,
   input  wire logic [1:0]        last_idx,
   input  wire logic [PORT_W-1:0] chunk_in,
   input  wire logic [31:0]       word_rd,
   output logic      [PORT_W-1:0] chunk_out,
   output logic      [31:0]       word_out,
   output logic                   word_done
);
   logic [1:0]  idx;
   logic [31:0] acc;
   wire  [1:0]  chunks_left = last_idx - idx;

   // Most significant chunk travels first
   assign chunk_out = PORT_W'(word_rd >> (int'(chunks_left) * PORT_W));
   assign word_out  = (acc << PORT_W) | 32'(chunk_in);
   assign word_done = step & (idx == last_idx);

   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         idx <= 2'h0;
         acc <= 32'h0000_0000;
      end
      else if (step)
      begin
         acc <= word_done ? 32'h0000_0000 : word_out;
         idx <= word_done ? 2'h0 : idx + 2'h1;
      end
   end
endmodule : cp_chunk_packer
`default_nettype wire

// ===== hw/fpu_cp_device.sv
`timescale 1ns/1ns
`default_nettype none
module fpu_cp_device #(
   parameter int         PORT_W = 32,
   parameter logic [2:0] CP_ID  = 3'h1
) (
   // Clock and reset
   input  wire logic              clk_sys,
   input  wire logic              reset,
   // Host bus
   cp_bus_if.device               bus,
   // Status
   output fpu_cp_pkg::cp_state_e  cp_state,
   output logic                   cp_busy
);
   import fpu_cp_pkg::*;

   localparam logic [1:0] OPND_LAST = 2'(32 / PORT_W - 1);
   localparam logic [1:0] CIR_LAST  = (PORT_W == 8) ? 2'h1 : 2'h0;
   localparam logic [1:0] ACK_CODE  = (PORT_W == 8)  ? ACK_BYTE :
                                      (PORT_W == 16) ? ACK_WORD : ACK_LONG;

   cp_state_e   state;
   logic        acked;
   logic [15:0] resp;
   logic [15:0] cmd;
   logic [31:0] operand;
   logic [7:0]  remaining;
   logic [66:0] shifted;
   logic        frame_rd;
   logic        frame_wr;
   logic [2:0]  frame_idx;
   logic [2:0]  frame_len;
   logic [31:0] frame_buf [0:FRAME_MAX-1];
   logic [31:0] fp_control_reg;
   logic [31:0] fp_status_reg;
   logic [31:0] fp_instr_address_reg;
   logic [79:0] fp_data_regs [0:7];

   ////////////////////////////////////////////////////////////////////////
   // Bus decode

   // Only CPU space with our ID; other spaces stay untouched
   wire hit  = bus.cyc & (bus.fc == FC_CPU_SPACE) & (bus.cp_id == CP_ID);
   wire take = hit & ~acked;
   wire is_opnd = bus.cir_sel == CIR_OPERAND;
   wire [1:0] last = is_opnd ? OPND_LAST : CIR_LAST;

   wire busy_ish = (state == ST_BUSY) | (state == ST_FETCH);
   wire near_done = (state == ST_BUSY) & (remaining < SAVE_COST);
   wire [15:0] save_fmt =
      (state == ST_NULL) ? FMT_NULL :
      (state == ST_IDLE) ? FMT_IDLE :
      near_done          ? FMT_AGAIN : FMT_BUSY;

   wire [31:0] frame_word =
      (frame_idx == 3'h0) ? fp_control_reg :
      (frame_idx == 3'h1) ? fp_status_reg :
      (frame_idx == 3'h2) ? fp_instr_address_reg :
      (frame_idx == 3'h3) ? {14'h0, state, cmd} :
      (frame_idx == 3'h4) ? {24'h0, remaining} : operand;

   wire [31:0] word_rd =
      (bus.cir_sel == CIR_RESPONSE) ? {16'h0, resp} :
      (bus.cir_sel == CIR_SAVE)     ? {16'h0, save_fmt} :
      (is_opnd & frame_rd)          ? frame_word : 32'h0000_0000;

   logic [PORT_W-1:0] chunk_out;
   logic [31:0]       word_out;
   logic              word_done;

   cp_chunk_packer #(.PORT_W(PORT_W)) packer (
      .clk_sys   (clk_sys),
      .reset     (reset),
      .step      (take),
      .last_idx  (last),
      .chunk_in  (bus.wdata[PORT_W-1:0]),
      .word_rd   (word_rd),
      .chunk_out (chunk_out),
      .word_out  (word_out),
      .word_done (word_done)
   );

   ////////////////////////////////////////////////////////////////////////
   // Completed register accesses

   wire w_cmd  = word_done & bus.wr & (bus.cir_sel == CIR_COMMAND);
   wire w_opnd = word_done & bus.wr & is_opnd;
   wire w_ctl  = word_done & bus.wr & (bus.cir_sel == CIR_CONTROL);
   wire w_rest = word_done & bus.wr & (bus.cir_sel == CIR_RESTORE);
   wire r_save = word_done & ~bus.wr & (bus.cir_sel == CIR_SAVE);
   wire r_opnd = word_done & ~bus.wr & is_opnd;

   wire null_rest = w_rest & (word_out[15:0] == FMT_NULL);
   wire core_rst  = reset | null_rest;
   wire frame_end = (frame_idx == frame_len - 3'h1);
   wire rest_done = w_opnd & frame_wr & frame_end;
   wire rest_busy = rest_done & (frame_len == FRAME_BUSY_LEN);
   wire abort     = w_ctl & word_out[CTRL_ABORT_BIT];

   // Operand now, or the one the command was waiting
   wire cmd_ok    = w_cmd & ~busy_ish;
   wire go_now    = cmd_ok & ~word_out[CMD_FETCH_BIT];
   wire go_opnd   = w_opnd & ~frame_wr & (state == ST_FETCH);
   wire start     = go_now | go_opnd;

   wire [15:0] exec_cmd = rest_busy ? frame_buf[3][15:0] :
                          w_cmd     ? word_out[15:0] : cmd;
   wire [31:0] exec_opnd = w_opnd ? word_out : operand;
   wire [6:0]  amt_raw = exec_cmd[CMD_AMT_MSB:0];
   wire [6:0]  amt = (amt_raw < SHIFT_MIN) ? SHIFT_MIN :
                     (amt_raw > SHIFT_MAX) ? SHIFT_MAX : amt_raw;
   // Whole shift in a single cycle
   wire [66:0] next_shifted = {exec_opnd, 35'h0} >> amt;
   wire [2:0]  dst = cmd[CMD_DST_LSB+2:CMD_DST_LSB];
   wire        finish = (state == ST_BUSY) & ~frame_rd & (remaining == 8'h1);

   ////////////////////////////////////////////////////////////////////////
   // Bus answer: held until the host drops its strobe, so the
   // handshake never depends on the host's clock rate

   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         acked                <= 1'b0;
         bus.size_acknowledge <= ACK_NONE;
         bus.rdata            <= 32'h0000_0000;
      end
      else if (take)
      begin
         acked                <= 1'b1;
         bus.size_acknowledge <= ACK_CODE;
         bus.rdata            <= 32'(chunk_out);
      end
      else if (acked & ~bus.cyc)
      begin
         acked                <= 1'b0;
         bus.size_acknowledge <= ACK_NONE;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Protocol and state sequencing

   // The only data path out is the read answer; no master port
   always_ff @(posedge clk_sys)
   begin
      if (core_rst)
      begin
         state     <= ST_NULL;
         resp      <= RESP_RELEASE;
         cmd       <= 16'h0000;
         operand   <= REG_RESET;
         remaining <= 8'h00;
         frame_rd  <= 1'b0;
         frame_wr  <= 1'b0;
         frame_idx <= 3'h0;
         frame_len <= 3'h0;
      end
      else if (abort)
      begin
         state    <= ST_IDLE;
         resp     <= RESP_RELEASE;
         frame_rd <= 1'b0;
         frame_wr <= 1'b0;
      end
      else
      begin
         if (w_cmd)
         begin
            resp <= ~cmd_ok ? RESP_BUSY :
                    go_now ? RESP_RELEASE : RESP_FETCH;
            if (cmd_ok)
            begin
               cmd   <= word_out[15:0];
               state <= go_now ? ST_BUSY : ST_FETCH;
            end
         end
         if (go_opnd)
         begin
            operand <= word_out;
            resp    <= RESP_RELEASE;
            state   <= ST_BUSY;
         end
         if (start)
            remaining <= EXEC_CYCLES;
         else if (state == ST_BUSY & ~frame_rd & remaining != 8'h0)
            remaining <= remaining - 8'h1;
         if (finish)
            state <= ST_IDLE;
         if (start | rest_busy)
            shifted <= next_shifted;
         // Save: idle frame, or halt mid-instruction
         if (r_save & (state == ST_IDLE | (busy_ish & ~near_done)))
         begin
            frame_rd  <= 1'b1;
            frame_idx <= 3'h0;
            frame_len <= save_fmt[2:0];
         end
         if (r_opnd & frame_rd)
         begin
            frame_idx <= frame_idx + 3'h1;
            if (frame_end)
            begin
               frame_rd <= 1'b0;
               state    <= ST_IDLE;
            end
         end
         if (w_rest & ~null_rest)
         begin
            frame_wr  <= 1'b1;
            frame_idx <= 3'h0;
            frame_len <= word_out[2:0];
         end
         if (w_opnd & frame_wr)
         begin
            frame_idx <= frame_idx + 3'h1;
            if (frame_end)
               frame_wr <= 1'b0;
         end
         if (rest_done)
         begin
            state <= rest_busy ? cp_state_e'(frame_buf[3][17:16])
                               : ST_IDLE;
            if (rest_busy)
            begin
               cmd       <= frame_buf[3][15:0];
               remaining <= frame_buf[4][7:0];
               operand   <= word_out;
            end
         end
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (w_opnd & frame_wr)
         frame_buf[frame_idx] <= word_out;
   end

   ////////////////////////////////////////////////////////////////////////
   // Programmer-visible registers

   always_ff @(posedge clk_sys)
   begin
      if (core_rst)
      begin
         fp_control_reg       <= REG_RESET;
         fp_status_reg        <= REG_RESET;
         fp_instr_address_reg <= REG_RESET;
         for (int i = 0; i < 8; i++)
            fp_data_regs[i] <= 80'h0;
      end
      else if (rest_done)
      begin
         fp_control_reg       <= frame_buf[0];
         fp_status_reg        <= frame_buf[1];
         fp_instr_address_reg <= (frame_len == 3'h3) ? word_out
                                                     : frame_buf[2];
      end
      else if (finish)
      begin
         fp_data_regs[dst] <= {FP_EXP_ONE, shifted[66:3]};
         fp_status_reg     <= fp_status_reg + 32'h1;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         cp_state <= ST_NULL;
         cp_busy  <= 1'b0;
      end
      else
      begin
         cp_state <= state;
         cp_busy  <= busy_ish;
      end
   end
endmodule : fpu_cp_device
`default_nettype wire

// ===== hw/fpu_cp_host.sv
`timescale 1ns/1ns
`default_nettype none
module fpu_cp_host #(
   parameter int         PORT_W = 32,
   parameter logic [2:0] CP_ID  = 3'h1
) (
   // Clock and reset
   input  wire logic               clk_sys,
   input  wire logic               reset,
   // Coprocessor bus
   cp_bus_if.host                  bus,
   // User requests
   input  wire logic               op_valid,
   input  wire fpu_cp_pkg::host_op_e op_kind,
   input  wire logic [15:0]        op_cmd,
   input  wire logic [31:0]        op_operand,
   output logic                    op_ready,
   output logic                    op_done,
   output logic [15:0]             op_resp
);
   import fpu_cp_pkg::*;

   localparam logic [1:0] OPND_LAST = 2'(32 / PORT_W - 1);
   localparam logic [1:0] CIR_LAST  = (PORT_W == 8) ? 2'h1 : 2'h0;

   host_phase_e phase;
   logic        start;
   logic        active;
   logic [1:0]  idx;
   logic [31:0] acc;
   logic [15:0] cmd;
   logic [31:0] operand;
   logic [15:0] fmt;
   logic [2:0]  k;
   logic [31:0] frame [0:FRAME_MAX-1];

   ////////////////////////////////////////////////////////////////////////
   // Unit selection from the phase

   wire opnd_ph = (phase == PH_OPND) | (phase == PH_FRAME_RD) |
                  (phase == PH_FRAME_WR);
   wire [4:0] unit_sel =
      (phase == PH_CMD)  ? CIR_COMMAND :
      (phase == PH_RESP) ? CIR_RESPONSE :
      (phase == PH_SAVE) ? CIR_SAVE :
      (phase == PH_REST) ? CIR_RESTORE : CIR_OPERAND;
   wire unit_wr = (phase == PH_CMD) | (phase == PH_OPND) |
                  (phase == PH_REST) | (phase == PH_FRAME_WR);
   wire [31:0] unit_word =
      (phase == PH_CMD)  ? {16'h0, cmd} :
      (phase == PH_OPND) ? operand :
      (phase == PH_REST) ? {16'h0, fmt} : frame[k];
   wire [1:0] last = opnd_ph ? OPND_LAST : CIR_LAST;
   wire [1:0] next_idx = start ? 2'h0 : idx + 2'h1;
   wire [1:0] left = last - next_idx;
   wire [31:0] next_wdata = unit_word >> (int'(left) * PORT_W);
   wire got_ack = bus.cyc & (bus.size_acknowledge != ACK_NONE);
   wire idle_bus = ~bus.cyc & (bus.size_acknowledge == ACK_NONE);
   wire unit_done = active & ~start & idle_bus & (idx == last);
   wire next_chunk = active & ~start & idle_bus & (idx != last);
   wire [15:0] a16 = acc[15:0];
   wire frame_last = (k == fmt[2:0] - 3'h1);

   ////////////////////////////////////////////////////////////////////////
   // Four-phase bus cycles, one chunk each, high chunk first

   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         active      <= 1'b0;
         idx         <= 2'h0;
         acc         <= 32'h0000_0000;
         bus.cyc     <= 1'b0;
         bus.wr      <= 1'b0;
         bus.fc      <= 3'h0;
         bus.cp_id   <= 3'h0;
         bus.cir_sel <= 5'h00;
         bus.wdata   <= 32'h0000_0000;
      end
      else if (start | next_chunk)
      begin
         active      <= 1'b1;
         idx         <= next_idx;
         bus.cyc     <= 1'b1;
         bus.wr      <= unit_wr;
         bus.fc      <= FC_CPU_SPACE;
         bus.cp_id   <= CP_ID;
         bus.cir_sel <= unit_sel;
         bus.wdata   <= 32'(next_wdata[PORT_W-1:0]);
         if (start)
            acc <= 32'h0000_0000;
      end
      else if (got_ack)
      begin
         bus.cyc <= 1'b0;
         acc     <= (acc << PORT_W) | 32'(bus.rdata[PORT_W-1:0]);
      end
      else if (unit_done)
         active <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // Dialogue sequencing

   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         phase    <= PH_IDLE;
         start    <= 1'b0;
         cmd      <= 16'h0000;
         operand  <= 32'h0000_0000;
         fmt      <= FMT_NULL;
         k        <= 3'h0;
         op_ready <= 1'b1;
         op_done  <= 1'b0;
         op_resp  <= 16'h0000;
      end
      else
      begin
         start   <= 1'b0;
         op_done <= 1'b0;
         if (phase == PH_IDLE & op_valid & op_ready)
         begin
            op_ready <= 1'b0;
            start    <= 1'b1;
            cmd      <= op_cmd;
            operand  <= op_operand;
            k        <= 3'h0;
            case (op_kind)
               OP_EXEC:    phase <= PH_CMD;
               OP_SAVE:    phase <= PH_SAVE;
               OP_RESTORE: phase <= PH_REST;
               default:
               begin
                  phase <= PH_REST;
                  fmt   <= FMT_NULL;
               end
            endcase
         end
         else if (unit_done)
         begin
            start <= 1'b1;
            case (phase)
               PH_CMD:  phase <= PH_RESP;
               PH_OPND: phase <= PH_RESP;
               PH_RESP:
                  if (a16 == RESP_FETCH)
                     phase <= PH_OPND;
                  else if (a16 == RESP_BUSY)
                     phase <= PH_CMD;
                  else
                  begin
                     // Free to move on; no wait for completion
                     phase    <= PH_IDLE;
                     start    <= 1'b0;
                     op_done  <= 1'b1;
                     op_ready <= 1'b1;
                     op_resp  <= a16;
                  end
               PH_SAVE:
                  if (a16 != FMT_AGAIN)
                  begin
                     fmt <= a16;
                     if (a16[2:0] == 3'h0)
                     begin
                        phase    <= PH_IDLE;
                        start    <= 1'b0;
                        op_done  <= 1'b1;
                        op_ready <= 1'b1;
                        op_resp  <= a16;
                     end
                     else
                        phase <= PH_FRAME_RD;
                  end
               PH_REST:
                  if (fmt[2:0] == 3'h0)
                  begin
                     phase    <= PH_IDLE;
                     start    <= 1'b0;
                     op_done  <= 1'b1;
                     op_ready <= 1'b1;
                     op_resp  <= fmt;
                  end
                  else
                     phase <= PH_FRAME_WR;
               default:
                  if (frame_last)
                  begin
                     phase    <= PH_IDLE;
                     start    <= 1'b0;
                     op_done  <= 1'b1;
                     op_ready <= 1'b1;
                     op_resp  <= fmt;
                  end
                  else
                     k <= k + 3'h1;
            endcase
         end
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (unit_done & phase == PH_FRAME_RD)
         frame[k] <= acc;
   end
endmodule : fpu_cp_host
`default_nettype wire

// ===== inc/cp_bus_if.sv
`timescale 1ns/1ns
`default_nettype none
interface cp_bus_if;
   logic        cyc;
   logic        wr;
   logic [2:0]  fc;
   logic [2:0]  cp_id;
   logic [4:0]  cir_sel;
   logic [31:0] wdata;
   logic [31:0] rdata;
   logic [1:0]  size_acknowledge;

   modport device (
      input  cyc, wr, fc, cp_id, cir_sel, wdata,
      output rdata, size_acknowledge
   );
   modport host (
      output cyc, wr, fc, cp_id, cir_sel, wdata,
      input  rdata, size_acknowledge
   );
endinterface : cp_bus_if
`default_nettype wire

// ===== inc/fpu_cp_pkg.sv
// Notes on behaviour
// - Transfers work on 8, 16, 32-bit ports
// - Host writes command, then reads response
// - Fetch response: host writes operand register
// - Host proceeds once requests are served
// - Cycles carry the CPU space function code
// - Three-bit ID selects one of eight
// - Works at any clock ratio to host
// - Device never masters; host moves all data
// - Save halts the operation in progress
// - Save in reset state: one null word
// - Idle save short; busy save full frame
// - Nearly finished instruction completes before save
// - Restore reloads state, resumes suspended work
// - Null restore equals hardware reset
// - Eight 80-bit data, three 32-bit registers
// - Barrel shift 1 to 67 in one cycle
`default_nettype none
package fpu_cp_pkg;
   localparam logic [2:0]  FC_CPU_SPACE = 3'h7;
   // Register select codes on the low address lines
   localparam logic [4:0]  CIR_RESPONSE = 5'h00;
   localparam logic [4:0]  CIR_CONTROL  = 5'h02;
   localparam logic [4:0]  CIR_SAVE     = 5'h04;
   localparam logic [4:0]  CIR_RESTORE  = 5'h06;
   localparam logic [4:0]  CIR_COMMAND  = 5'h0a;
   localparam logic [4:0]  CIR_OPERAND  = 5'h10;
   // Size acknowledge codes
   localparam logic [1:0]  ACK_NONE     = 2'h0;
   localparam logic [1:0]  ACK_BYTE     = 2'h1;
   localparam logic [1:0]  ACK_WORD     = 2'h2;
   localparam logic [1:0]  ACK_LONG     = 2'h3;
   // Response words
   localparam logic [15:0] RESP_RELEASE = 16'h0001;
   localparam logic [15:0] RESP_FETCH   = 16'h0002;
   localparam logic [15:0] RESP_BUSY    = 16'h0004;
   // Save format words: low three bits give the frame length
   localparam logic [15:0] FMT_NULL     = 16'h0000;
   localparam logic [15:0] FMT_AGAIN    = 16'h0100;
   localparam logic [15:0] FMT_IDLE     = 16'h1003;
   localparam logic [15:0] FMT_BUSY     = 16'h1006;
   localparam int          FRAME_MAX    = 6;
   localparam logic [2:0]  FRAME_BUSY_LEN = 3'h6;
   // Command word fields
   localparam int          CMD_FETCH_BIT = 15;
   localparam int          CMD_DST_LSB   = 10;
   localparam int          CMD_AMT_MSB   = 6;
   localparam int          CTRL_ABORT_BIT = 14;
   // Shifter limits
   localparam logic [6:0]  SHIFT_MIN    = 7'h01;
   localparam logic [6:0]  SHIFT_MAX    = 7'h43;
   localparam logic [15:0] FP_EXP_ONE   = 16'h3fff;
   // Cycle counts
   localparam logic [7:0]  EXEC_CYCLES  = 8'h28;
   localparam logic [7:0]  SAVE_COST    = 8'h0c;
   // Reset values
   localparam logic [31:0] REG_RESET    = 32'h0000_0000;

   typedef enum logic [1:0] {
      ST_NULL  = 2'b00,
      ST_IDLE  = 2'b01,
      ST_BUSY  = 2'b10,
      ST_FETCH = 2'b11
   } cp_state_e;

   typedef enum logic [1:0] {
      OP_EXEC    = 2'b00,
      OP_SAVE    = 2'b01,
      OP_RESTORE = 2'b10,
      OP_RESET   = 2'b11
   } host_op_e;

   typedef enum logic [2:0] {
      PH_IDLE     = 3'b000,
      PH_CMD      = 3'b001,
      PH_RESP     = 3'b010,
      PH_OPND     = 3'b011,
      PH_SAVE     = 3'b100,
      PH_FRAME_RD = 3'b101,
      PH_REST     = 3'b110,
      PH_FRAME_WR = 3'b111
   } host_phase_e;
endpackage : fpu_cp_pkg
`default_nettype wire
